// ---- pkg/charger_stim_pkg.sv ----
package charger_stim_pkg;

	// ****************************************************
	// Register offsets
	// ****************************************************
	localparam logic [7:0] ADDR_STIM2_PULLDOWN_THRESHOLD = 8'h47;
	localparam logic [7:0] ADDR_STIM2_DIVIDER_RATIO = 8'h48;
	localparam logic [7:0] ADDR_STIM3_TIMING_SELECT = 8'h49;
	localparam logic [7:0] ADDR_STIM3_RESPONSE = 8'h4a;

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int SINK_CURRENT_LSB = 4;
	localparam int THRESHOLD_LSB = 0;
	localparam int RATIO_LSB = 0;
	localparam int TIMER_TYPE_BIT = 6;
	localparam int DELAY_LSB = 3;
	localparam int DETECT_SELECT_LSB = 0;
	localparam int RESPONSE_LEVEL_LSB = 4;
	localparam int RESPONSE_KIND_LSB = 0;

	// ****************************************************
	// Reset values
	// ****************************************************
	localparam logic [1:0] SINK_CURRENT_RST = 2'h0;
	localparam logic [3:0] THRESHOLD_RST = 4'h0;
	localparam logic [2:0] RATIO_RST = 3'h0;
	localparam logic TIMER_TYPE_RST = 1'b0;
	localparam logic [2:0] DELAY_RST = 3'h0;
	localparam logic [2:0] DETECT_SELECT_RST = 3'h0;
	localparam logic [3:0] RESPONSE_LEVEL_RST = 4'h0;
	localparam logic [3:0] RESPONSE_KIND_RST = 4'h0;

	// ****************************************************
	// Codes
	// ****************************************************
	localparam logic [2:0] RATIO_RESERVED = 3'h7;
	localparam logic [3:0] LEVEL_RESERVED = 4'hf;
	localparam logic [3:0] KIND_REMOVE = 4'h0;
	localparam logic [3:0] KIND_RSVD_A = 4'h5;
	localparam logic [3:0] KIND_RSVD_B = 4'h8;
	localparam logic [3:0] KIND_RSVD_C = 4'hb;
	localparam logic [3:0] KIND_DIV_DP = 4'h6;
	localparam logic [3:0] KIND_DIV_DM = 4'h9;
	localparam logic [3:0] KIND_DIV_BOTH = 4'hc;
	localparam logic [2:0] SEL_VBUS_READY = 3'h0;
	localparam logic [2:0] SEL_DP_ABOVE = 3'h1;
	localparam logic [2:0] SEL_DP_WINDOW = 3'h2;
	localparam logic [2:0] SEL_DM_ABOVE = 3'h3;
	localparam logic [2:0] SEL_RSVD_A = 3'h4;
	localparam logic [2:0] SEL_RSVD_B = 3'h5;
	localparam logic [2:0] SEL_DP_ABOVE_ALT = 3'h6;
	localparam logic [2:0] SEL_VBUS_PRESENT = 3'h7;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_IN_NS = 1000000;
	localparam int MS_CYCLES = MS_IN_NS / CLK_PERIOD_NS;

	// ****************************************************
	// Types
	// ****************************************************
	typedef struct packed {
		logic [1:0] sinkCurrent;
		logic [3:0] threshold;
	} bc12_settings_t;

	typedef struct packed {
		logic timerType;
		logic [2:0] delayCode;
		logic [2:0] detectSelect;
		logic [3:0] responseLevel;
		logic [3:0] responseKind;
	} third_step_t;

	typedef struct packed {
		logic dpAboveThreshold;
		logic dmAboveThreshold;
		logic dpAboveFloor;
		logic vbusReady;
		logic vbusPresent;
	} line_sense_t;

	typedef enum logic [3:0] {
		TMR_IDLE = 4'b0001,
		TMR_DELAY = 4'b0010,
		TMR_APPLY = 4'b0100,
		TMR_DONE = 4'b1000
	} timer_state_t;

	// Delay code to milliseconds
	function automatic logic [6:0] delay_ms(input logic [2:0] code);
		case (code)
			3'h0: delay_ms = 7'h00;
			3'h1: delay_ms = 7'h01;
			3'h2: delay_ms = 7'h05;
			3'h3: delay_ms = 7'h0a;
			3'h4: delay_ms = 7'h14;
			3'h5: delay_ms = 7'h28;
			3'h6: delay_ms = 7'h50;
			default: delay_ms = 7'h64;
		endcase
	endfunction

endpackage

// ---- rtl/stim_response_timer.sv ----
module stim_response_timer #(
	parameter int MsCycles = charger_stim_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic detect,
	input wire logic timerType,
	input wire logic [2:0] delayCode,
	output logic responseActive
);
	import charger_stim_pkg::*;

	// ****************************************************
	// Millisecond divider and state
	// ****************************************************
	timer_state_t state_ff, nxt_state;
	logic [31:0] div_ff, nxt_div;
	logic [6:0] msLeft_ff, nxt_msLeft;
	logic active_ff, nxt_active;
	logic tick;

	assign tick = (div_ff == 32'(MsCycles - 1));
	assign responseActive = active_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_div = tick ? 32'h0 : div_ff + 32'h1;
		nxt_msLeft = (tick && msLeft_ff != 7'h00) ? msLeft_ff - 7'h01 : msLeft_ff;
		nxt_active = active_ff;
		case (state_ff)
			TMR_IDLE: begin
				nxt_active = 1'b0;
				if (detect) begin
					nxt_div = 32'h0;
					nxt_msLeft = delay_ms(delayCode);
					if (timerType) begin
						nxt_state = TMR_APPLY;
						nxt_active = 1'b1;
					end else if (delay_ms(delayCode) == 7'h00) begin
						nxt_state = TMR_DONE;
						nxt_active = 1'b1;
					end else begin
						nxt_state = TMR_DELAY;
					end
				end
			end
			TMR_DELAY: begin
				if (msLeft_ff == 7'h00) begin
					nxt_state = TMR_DONE;
					nxt_active = 1'b1;
				end
			end
			TMR_APPLY: begin
				if (msLeft_ff == 7'h00 && !detect) begin
					nxt_state = TMR_IDLE;
					nxt_active = 1'b0;
				end
			end
			TMR_DONE: begin
				nxt_active = 1'b1;
			end
			default: begin
				nxt_state = TMR_IDLE;
				nxt_active = 1'b0;
			end
		endcase
		if (!enable) begin
			nxt_state = TMR_IDLE;
			nxt_active = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= TMR_IDLE;
			div_ff <= 32'h0;
			msLeft_ff <= 7'h00;
			active_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			div_ff <= nxt_div;
			msLeft_ff <= nxt_msLeft;
			active_ff <= nxt_active;
		end
	end

endmodule

// ---- rtl/custom_charger_stimulus_config.sv ----
module custom_charger_stimulus_config #(
	parameter int MsCycles = charger_stim_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic charger_profile_cycle,
	input wire logic bc12ProfileActive,
	input wire logic [3:0] second_step_response_kind,
	input wire charger_stim_pkg::line_sense_t lineSense,
	output charger_stim_pkg::bc12_settings_t bc12Settings,
	output logic [2:0] second_step_divider_ratio,
	output logic dividerRatioValid,
	output charger_stim_pkg::third_step_t thirdStep,
	output logic thirdStepDetected,
	output logic thirdStepNoWait,
	output logic thirdStepResponseActive,
	output logic thirdStepRemoveResponse
);
	import charger_stim_pkg::*;

	// ****************************************************
	// Stored fields
	// ****************************************************
	logic [1:0] sinkCur_ff, nxt_sinkCur;
	logic [3:0] thresh_ff, nxt_thresh;
	logic [2:0] ratio_ff, nxt_ratio;
	third_step_t s3_ff, nxt_s3;

	// Response kinds that a write may not store
	function automatic logic kind_reserved(input logic [3:0] k);
		kind_reserved = (k == KIND_RSVD_A) || (k == KIND_RSVD_B) || (k == KIND_RSVD_C);
	endfunction

	always_comb begin
		nxt_sinkCur = sinkCur_ff;
		nxt_thresh = thresh_ff;
		nxt_ratio = ratio_ff;
		nxt_s3 = s3_ff;
		if (regWrEn) begin
			case (regAddr)
				ADDR_STIM2_PULLDOWN_THRESHOLD: begin
					nxt_sinkCur = regWrData[SINK_CURRENT_LSB +: 2];
					nxt_thresh = regWrData[THRESHOLD_LSB +: 4];
				end
				ADDR_STIM2_DIVIDER_RATIO: begin
					if (regWrData[RATIO_LSB +: 3] != RATIO_RESERVED) begin
						nxt_ratio = regWrData[RATIO_LSB +: 3];
					end
				end
				ADDR_STIM3_TIMING_SELECT: begin
					nxt_s3.timerType = regWrData[TIMER_TYPE_BIT];
					nxt_s3.delayCode = regWrData[DELAY_LSB +: 3];
					if (regWrData[DETECT_SELECT_LSB +: 3] != SEL_RSVD_A &&
						regWrData[DETECT_SELECT_LSB +: 3] != SEL_RSVD_B) begin
						nxt_s3.detectSelect = regWrData[DETECT_SELECT_LSB +: 3];
					end
				end
				ADDR_STIM3_RESPONSE: begin
					if (regWrData[RESPONSE_LEVEL_LSB +: 4] != LEVEL_RESERVED) begin
						nxt_s3.responseLevel = regWrData[RESPONSE_LEVEL_LSB +: 4];
					end
					if (!kind_reserved(regWrData[RESPONSE_KIND_LSB +: 4])) begin
						nxt_s3.responseKind = regWrData[RESPONSE_KIND_LSB +: 4];
					end
				end
				default: begin
					nxt_ratio = ratio_ff;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sinkCur_ff <= SINK_CURRENT_RST;
			thresh_ff <= THRESHOLD_RST;
			ratio_ff <= RATIO_RST;
			s3_ff <= {TIMER_TYPE_RST, DELAY_RST, DETECT_SELECT_RST, RESPONSE_LEVEL_RST,
				RESPONSE_KIND_RST};
		end else begin
			sinkCur_ff <= nxt_sinkCur;
			thresh_ff <= nxt_thresh;
			ratio_ff <= nxt_ratio;
			s3_ff <= nxt_s3;
		end
	end

	// ****************************************************
	// Read-back
	// ****************************************************
	always_comb begin
		case (regAddr)
			ADDR_STIM2_PULLDOWN_THRESHOLD: regRdData = {2'h0, sinkCur_ff, thresh_ff};
			ADDR_STIM2_DIVIDER_RATIO: regRdData = {5'h00, ratio_ff};
			ADDR_STIM3_TIMING_SELECT: regRdData = {1'b0, s3_ff.timerType, s3_ff.delayCode,
				s3_ff.detectSelect};
			ADDR_STIM3_RESPONSE: regRdData = {s3_ff.responseLevel, s3_ff.responseKind};
			default: regRdData = 8'h00;
		endcase
	end

	// ****************************************************
	// Profile-gated copies for the emulation engine
	// ****************************************************
	bc12_settings_t bc12_ff, nxt_bc12;
	logic [2:0] useRatio_ff, nxt_useRatio;

	// Engine copies freeze while the other profile runs
	always_comb begin
		nxt_bc12 = bc12_ff;
		nxt_useRatio = useRatio_ff;
		if (bc12ProfileActive) begin
			nxt_bc12 = '{sinkCurrent: sinkCur_ff, threshold: thresh_ff};
		end else begin
			nxt_useRatio = ratio_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bc12_ff <= '{sinkCurrent: SINK_CURRENT_RST, threshold: THRESHOLD_RST};
			useRatio_ff <= RATIO_RST;
		end else begin
			bc12_ff <= nxt_bc12;
			useRatio_ff <= nxt_useRatio;
		end
	end

	assign bc12Settings = bc12_ff;
	assign second_step_divider_ratio = useRatio_ff;
	assign dividerRatioValid = !bc12ProfileActive &&
		(second_step_response_kind == KIND_DIV_DP ||
		second_step_response_kind == KIND_DIV_DM ||
		second_step_response_kind == KIND_DIV_BOTH);
	assign thirdStep = s3_ff;

	// ****************************************************
	// Line sense synchroniser and detect decode
	// ****************************************************
	// Comparator outputs are asynchronous: two flops first
	line_sense_t senseMeta_ff, sense_ff;
	logic detect_ff, nxt_detect;
	logic noWait_ff, nxt_noWait;

	always_comb begin
		nxt_noWait = 1'b0;
		nxt_detect = 1'b0;
		case (s3_ff.detectSelect)
			SEL_VBUS_READY: begin
				nxt_detect = sense_ff.vbusReady;
				nxt_noWait = 1'b1;
			end
			SEL_DP_ABOVE, SEL_DP_ABOVE_ALT: nxt_detect = sense_ff.dpAboveThreshold;
			SEL_DM_ABOVE: nxt_detect = sense_ff.dmAboveThreshold;
			SEL_DP_WINDOW: nxt_detect = !sense_ff.dpAboveThreshold &&
				sense_ff.dpAboveFloor;
			SEL_VBUS_PRESENT: begin
				nxt_detect = sense_ff.vbusPresent;
				nxt_noWait = 1'b1;
			end
			default: nxt_detect = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			senseMeta_ff <= '0;
			sense_ff <= '0;
			detect_ff <= 1'b0;
			noWait_ff <= 1'b0;
		end else begin
			senseMeta_ff <= lineSense;
			sense_ff <= senseMeta_ff;
			detect_ff <= nxt_detect;
			noWait_ff <= nxt_noWait;
		end
	end

	assign thirdStepDetected = detect_ff;
	assign thirdStepNoWait = noWait_ff;
	assign thirdStepRemoveResponse = (s3_ff.responseKind == KIND_REMOVE);

	// ****************************************************
	// Response timing
	// ****************************************************
	// Rearms only from idle; cycle end clears the response
	stim_response_timer #(
		.MsCycles(MsCycles)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.enable(charger_profile_cycle),
		.detect(detect_ff),
		.timerType(s3_ff.timerType),
		.delayCode(s3_ff.delayCode),
		.responseActive(thirdStepResponseActive)
	);

endmodule

// ---- test/device_model.sv ----
module device_model (
	input wire logic [11:0] dpMv,
	input wire logic [11:0] dmMv,
	input wire logic [11:0] thMv,
	input wire logic [1:0] vbus,
	output charger_stim_pkg::line_sense_t lineSense
);
	timeunit 1ns;
	timeprecision 1ns;
	import charger_stim_pkg::*;
	// Line comparators as the attached device presents them
	assign lineSense = '{dpMv > thMv, dmMv > thMv, dpMv > 12'h190, vbus[1], vbus[0]};
endmodule

// ---- test/config_chk.sv ----
module config_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic bc12ProfileActive,
	input wire logic [3:0] second_step_response_kind,
	input wire charger_stim_pkg::bc12_settings_t bc12Settings,
	input wire logic [2:0] second_step_divider_ratio,
	input wire logic dividerRatioValid,
	input wire charger_stim_pkg::third_step_t thirdStep,
	input wire logic thirdStepNoWait,
	input wire logic thirdStepRemoveResponse
);
	timeunit 1ns;
	timeprecision 1ns;
	import charger_stim_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence wrSel;
		regWrEn && regAddr == ADDR_STIM3_TIMING_SELECT;
	endsequence
	sequence wrResp;
		regWrEn && regAddr == ADDR_STIM3_RESPONSE;
	endsequence
	sequence selNoWait;
		thirdStep.detectSelect inside {3'h0, 3'h7};
	endsequence
	AST_SEL_RSVD: assert property (wrSel ##0 regWrData[2:1] == 2'h2
		|=> $stable(thirdStep.detectSelect)) else $error("reserved select stored");
	AST_LEVEL_RSVD: assert property (wrResp ##0 regWrData[7:4] == 4'hf
		|=> $stable(thirdStep.responseLevel)) else $error("reserved level stored");
	AST_KIND_LOAD: assert property (wrResp
		##0 !(regWrData[3:0] inside {4'h5, 4'h8, 4'hb})
		|=> thirdStep.responseKind == $past(regWrData[3:0])) else $error("kind not loaded");
	AST_TYPE_LOAD: assert property (wrSel
		|=> thirdStep.timerType == $past(regWrData[6])) else $error("timer type not loaded");
	AST_DELAY_LOAD: assert property (wrSel
		|=> thirdStep.delayCode == $past(regWrData[5:3])) else $error("delay not loaded");
	AST_REMOVE: assert property (thirdStepRemoveResponse
		== (thirdStep.responseKind == 4'h0)) else $error("remove flag wrong");
	AST_RATIO_VALID: assert property (dividerRatioValid == (!bc12ProfileActive &&
		second_step_response_kind inside {4'h6, 4'h9, 4'hc})) else $error("ratio valid wrong");
	AST_NOWAIT: assert property (selNoWait ##1 selNoWait |-> thirdStepNoWait)
		else $error("no-wait flag low");
	AST_RATIO_HOLD: assert property (bc12ProfileActive
		|=> $stable(second_step_divider_ratio)) else $error("ratio copy moved");
	AST_BC12_HOLD: assert property (!bc12ProfileActive |=> $stable(bc12Settings))
		else $error("sink settings moved");
endmodule

bind custom_charger_stimulus_config config_chk u_config_chk (.clk, .rst_n, .regAddr, .regWrEn,
	.regWrData, .bc12ProfileActive, .second_step_response_kind, .bc12Settings,
	.second_step_divider_ratio, .dividerRatioValid, .thirdStep, .thirdStepNoWait,
	.thirdStepRemoveResponse);

// ---- test/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import charger_stim_pkg::*;
	localparam int M = 10;
	logic clk, rst_n, regWrEn, cyc, bc12, e, det, noWait, act, rem, ratioValid;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [3:0] kind2;
	logic [11:0] dp, dm, th;
	logic [1:0] vb;
	logic [2:0] ratio, s;
	line_sense_t lineSense;
	bc12_settings_t bc12Settings;
	third_step_t ts;
	int errors, compares, n;
	int mdl[8'h46:8'h4b];
	int msTab[8] = '{0, 1, 5, 10, 20, 40, 80, 100};
	logic [2:0] selTab[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	logic [15:0] rsv[6] = '{16'h48ff, 16'h49fc, 16'h49fd, 16'h4af5, 16'h4a18, 16'h4afb};

	device_model u_device_model (.dpMv(dp), .dmMv(dm), .thMv(th), .vbus(vb), .lineSense);
	custom_charger_stimulus_config #(.MsCycles(M)) u_custom_charger_stimulus_config (.clk,
		.rst_n, .regAddr, .regWrEn, .regWrData, .regRdData, .charger_profile_cycle(cyc),
		.bc12ProfileActive(bc12), .second_step_response_kind(kind2), .lineSense, .bc12Settings,
		.second_step_divider_ratio(ratio), .dividerRatioValid(ratioValid), .thirdStep(ts),
		.thirdStepDetected(det), .thirdStepNoWait(noWait), .thirdStepResponseActive(act),
		.thirdStepRemoveResponse(rem));

	// ****************************************************
	// Compare tasks, one per kind of result
	// ****************************************************
	task automatic chkReg(string nm, logic [15:0] x, logic [15:0] g);
		compares++;
		if (x !== g) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, x, g);
		end
	endtask

	task automatic chkCopy(string nm, logic [15:0] x, logic [15:0] g);
		compares++;
		if (x !== g) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, x, g);
		end
	endtask

	task automatic chkDetect(string nm, logic [15:0] x, logic [15:0] g);
		compares++;
		if (x !== g) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, x, g);
		end
	endtask

	task automatic chkTimer(string nm, logic [15:0] x, logic [15:0] g);
		compares++;
		if (x !== g) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, x, g);
		end
	endtask

	// ****************************************************
	// Register access with reference model update
	// ****************************************************
	task automatic wr(logic [7:0] a, logic [7:0] d);
		int o;
		@(negedge clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1;
		@(negedge clk);
		regWrEn = 0;
		o = mdl[a];
		case (a)
			8'h47: mdl[a] = d & 8'h3f;
			8'h48: if (d[2:0] != 3'h7) mdl[a] = d[2:0];
			8'h49: mdl[a] = {1'b0, d[6:3], (d[2:1] == 2'h2) ? o[2:0] : d[2:0]};
			8'h4a: mdl[a] = {(d[7:4] == 4'hf) ? o[7:4] : d[7:4],
				(d[3:0] inside {4'h5, 4'h8, 4'hb}) ? o[3:0] : d[3:0]};
			default: ;
		endcase
	endtask

	task automatic rd(logic [7:0] a);
		@(negedge clk);
		regAddr = a;
		#1 chkReg("read", (a inside {[8'h47:8'h4a]}) ? mdl[a] : 32'h0, regRdData);
		chkReg("fields", {mdl[8'h49][6:0], mdl[8'h4a][7:0]}, ts);
		chkReg("remove", mdl[8'h4a][3:0] == 4'h0, rem);
	endtask

	task automatic conclude();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	initial begin
		#(12000 * 50);
		errors++;
		conclude();
	end

	initial begin
		{rst_n, regWrEn, regAddr, regWrData, cyc, bc12, kind2, dp, dm, th, vb} = '0;
		void'($urandom(32'h61bd7d62));
		repeat (6) @(negedge clk);
		rst_n = 1;
		for (int a = 8'h46; a <= 8'h4b; a++) rd(a[7:0]);
		$display("reset test done");
		repeat (60) begin
			n = 8'h46 + $urandom_range(5);
			wr(n[7:0], 8'($urandom));
			rd(n[7:0]);
		end
		foreach (rsv[i]) begin
			wr(rsv[i][15:8], rsv[i][7:0]);
			rd(rsv[i][15:8]);
		end
		$display("register test done");
		// Mid-run reset clears every stored field
		@(negedge clk);
		rst_n = 0;
		repeat (3) @(negedge clk);
		rst_n = 1;
		foreach (mdl[j]) mdl[j] = 0;
		for (int a = 8'h46; a <= 8'h4b; a++) rd(a[7:0]);
		$display("second reset test done");
		wr(8'h48, 8'h03);
		repeat (2) @(negedge clk);
		chkCopy("ratio", 3'h3, ratio);
		bc12 = 1;
		wr(8'h48, 8'h05);
		wr(8'h47, 8'h2a);
		repeat (2) @(negedge clk);
		chkCopy("ratio", 3'h3, ratio);
		chkCopy("sink", 6'h2a, bc12Settings);
		bc12 = 0;
		wr(8'h47, 8'h15);
		repeat (2) @(negedge clk);
		chkCopy("sink", 6'h2a, bc12Settings);
		chkCopy("ratio", 3'h5, ratio);
		for (int k = 0; k < 32; k++) begin
			@(negedge clk);
			bc12 = k[4];
			kind2 = k[3:0];
			#1 chkCopy("valid", !k[4] && k[3:0] inside {4'h6, 4'h9, 4'hc}, ratioValid);
		end
		$display("profile test done");
		repeat (40) begin
			s = selTab[$urandom_range(5)];
			wr(8'h49, {5'h0, s});
			dp = 12'($urandom_range(1500));
			dm = 12'($urandom_range(1500));
			th = 12'($urandom_range(1500));
			vb = 2'($urandom);
			if (dp == th) dp++;
			repeat (5) @(negedge clk);
			case (s)
				3'h0: e = vb[1];
				3'h7: e = vb[0];
				3'h3: e = dm > th;
				3'h2: e = dp < th && dp > 12'h190;
				default: e = dp > th;
			endcase
			chkDetect("detect", e, det);
			chkDetect("nowait", s inside {3'h0, 3'h7}, noWait);
		end
		$display("detect test done");
		th = 12'h1f4;
		for (int c = 0; c < 9; c++) begin
			cyc = 0;
			dp = 12'h000;
			wr(8'h49, (c < 8) ? {2'h0, c[2:0], 3'h1} : 8'h49);
			repeat (5) @(negedge clk);
			cyc = 1;
			dp = 12'h384;
			for (n = 0; det !== 1'b1 && n < 20; n++) @(negedge clk);
			for (n = 0; act !== 1'b1 && n < 1100; n++) @(negedge clk);
			if (c < 8)
				chkTimer("delay", 1'b1, n >= msTab[c] * M && n <= msTab[c] * M + 3);
			else
				chkTimer("immediate", 1'b1, n <= 1);
			repeat (3 * M) @(negedge clk);
			chkTimer("held", 1'b1, act);
			dp = 12'h000;
			repeat (8) @(negedge clk);
			chkTimer("hold", c < 8, act);
		end
		$display("timer test done");
		conclude();
	end
endmodule
